// ### rtl/mcu_core_branch_bit_regs.sv
// Branch and bit-instruction core with its pointer and accumulator registers.
// Assumes code memory answers code_data combinationally for code_addr, and an
// Avalon-MM master that holds each request until waitrequest is low.
`default_nettype none

module mcu_core_branch_bit_regs
  import mcu_core_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic [15:0] code_addr,
  input wire logic [7:0] code_data
);

  logic [7:0] iram [0:255];
  logic [7:0] stack_pointer;
  logic [7:0] data_pointer_low;
  logic [7:0] data_pointer_high;
  logic [7:0] arith_primary_reg;
  logic [7:0] arith_secondary_reg;
  logic [7:0] psw;
  logic run;
  logic [15:0] pc;
  logic [15:0] op_pc;
  logic [15:0] jump_target;
  logic [7:0] opcode;
  logic [7:0] b1;
  logic [7:0] b2;
  logic [2:0] cnt;
  phase_t phase;
  logic bus_ack;
  logic bus_req;
  logic bus_wr;
  logic go;
  logic active;
  logic start;
  logic exec;
  logic [7:0] cur_op;
  logic [7:0] op1;
  logic [7:0] op2;
  logic [15:0] base_pc;
  logic [15:0] fallthrough;
  logic [4:0] ft_page;
  kind_t kind;
  dec_t dec;
  logic taken;
  logic [15:0] target;
  logic dwr_en;
  logic [7:0] dwr_addr;
  logic [7:0] dwr_data;
  logic carry_en;
  logic carry_val;
  logic push;
  logic pop;

  // Direct-space read: low half is data RAM, high half special registers
  function automatic logic [7:0] rd_direct(input logic [7:0] a);
    if (!a[7]) begin
      return iram[a];
    end
    case (a)
      SFR_STACK: return stack_pointer;
      SFR_PTR_LOW: return data_pointer_low;
      SFR_PTR_HIGH: return data_pointer_high;
      SFR_PSW: return {psw[7:1], ^arith_primary_reg};
      SFR_ARITH_PRI: return arith_primary_reg;
      SFR_ARITH_SEC: return arith_secondary_reg;
      SFR_PC_LOW: return pc[7:0];
      SFR_PC_HIGH: return pc[15:8];
      SFR_CTRL: return {7'h00, run};
      default: return 8'h00;
    endcase
  endfunction : rd_direct

  // Opcode to instruction kind; unlisted opcodes run as no-operation
  function automatic kind_t classify(input logic [7:0] op);
    kind_t k;
    k = K_NOP;
    if (op[4:0] == OP_JMP_ABS_LOW) begin
      k = K_JMPAB;
    end else if (op[4:0] == OP_CALL_ABS_LOW) begin
      k = K_CALLA;
    end else if (op[7:3] == OP_CMP_RN_HI) begin
      k = K_CMP_RI;
    end else if (op[7:3] == OP_DEC_JMP_RN_HI) begin
      k = K_DECJ_R;
    end else if (op[7:1] == OP_CMP_IND_HI) begin
      k = K_CMP_II;
    end else begin
      case (op)
        OP_ANL_C, OP_ANL_CN: k = K_ANLC;
        OP_ORL_C, OP_ORL_CN: k = K_ORLC;
        OP_MOV_CB: k = K_MOVCB;
        OP_MOV_BC: k = K_MOVBC;
        OP_JC: k = K_JC;
        OP_JNC: k = K_JNC;
        OP_JB: k = K_JB;
        OP_JNB: k = K_JNB;
        OP_JMP_BIT_CLR: k = K_JBCLR;
        OP_CALL_LONG: k = K_CALLL;
        OP_JMP_LONG: k = K_JMPL;
        OP_RET, OP_RET_INT: k = K_RET;
        OP_JMP_SHORT: k = K_JMPS;
        OP_JMPA: k = K_JMPA;
        OP_JZ: k = K_JZ;
        OP_JNZ: k = K_JNZ;
        OP_CMP_AD: k = K_CMP_AD;
        OP_CMP_AI: k = K_CMP_AI;
        OP_DEC_JMP_D: k = K_DECJ_D;
        OP_NOP, OP_SPARE_NOP: k = K_NOP;
        default: k = K_NOP;
      endcase
    end
    return k;
  endfunction : classify

  // Length, base cycles and the extra cycle of a taken branch
  function automatic dec_t decode(input kind_t k);
    dec_t d;
    d = '{len: LEN_ONE, base: CYC_NOP, extra: 1'b0};
    case (k)
      K_ANLC, K_ORLC: d = '{len: LEN_TWO, base: CYC_BIT, extra: 1'b0};
      K_MOVCB, K_MOVBC: d = '{len: LEN_TWO, base: CYC_BIT, extra: 1'b0};
      K_JC, K_JNC: d = '{len: LEN_TWO, base: CYC_JC, extra: 1'b1};
      K_JB, K_JNB, K_JBCLR: d = '{len: LEN_THREE, base: CYC_JB, extra: 1'b1};
      K_CALLA, K_JMPAB: d = '{len: LEN_TWO, base: CYC_ABS, extra: 1'b0};
      K_CALLL, K_JMPL: d = '{len: LEN_THREE, base: CYC_LONG, extra: 1'b0};
      K_RET: d = '{len: LEN_ONE, base: CYC_RET, extra: 1'b0};
      K_JMPS: d = '{len: LEN_TWO, base: CYC_SHORT, extra: 1'b0};
      K_JMPA: d = '{len: LEN_ONE, base: CYC_SHORT, extra: 1'b0};
      K_JZ, K_JNZ: d = '{len: LEN_TWO, base: CYC_JZ, extra: 1'b1};
      K_CMP_AD, K_CMP_II: d = '{len: LEN_THREE, base: CYC_CMP_MEM, extra: 1'b1};
      K_CMP_AI, K_CMP_RI: d = '{len: LEN_THREE, base: CYC_CMP_IMM, extra: 1'b1};
      K_DECJ_R: d = '{len: LEN_TWO, base: CYC_DEC_R, extra: 1'b1};
      K_DECJ_D: d = '{len: LEN_THREE, base: CYC_DEC_D, extra: 1'b1};
      default: d = '{len: LEN_ONE, base: CYC_NOP, extra: 1'b0};
    endcase
    return d;
  endfunction : decode

  // Bus handshake: one wait cycle, core frozen in the answer cycle
  assign bus_req = avs_read | avs_write;
  assign avs_waitrequest = bus_req & ~bus_ack;
  assign bus_wr = avs_write & bus_ack & avs_byteenable[0];
  assign go = ~bus_ack;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      bus_ack <= 1'b0;
      avs_readdata <= 32'h0000_0000;
    end else begin
      bus_ack <= bus_req & ~bus_ack;
      if (avs_read && !bus_ack) begin
        avs_readdata <= {24'h00_0000, rd_direct(avs_address)};
      end
    end
  end

  // Sequencing view of the current instruction
  assign active = go && (phase == PH_OPER || (phase == PH_FETCH && run));
  assign start = active && phase == PH_FETCH;
  assign cur_op = (phase == PH_FETCH) ? code_data : opcode;
  assign op1 = (cnt == 3'h1) ? code_data : b1;
  assign op2 = (cnt == 3'h2) ? code_data : b2;
  assign base_pc = (phase == PH_FETCH) ? pc : op_pc;
  assign fallthrough = base_pc + {14'h0000, dec.len};
  assign ft_page = fallthrough[15:11];
  assign kind = classify(cur_op);
  assign dec = decode(kind);
  assign exec = active && cnt == dec.base - 3'h1;
  assign code_addr = pc;

  // Instruction behaviour evaluated in its last base cycle
  always_comb begin
    logic [7:0] bit_byte_addr;
    logic [7:0] bit_byte;
    logic bit_val;
    logic [7:0] rel;
    logic [15:0] rel_target;
    logic [7:0] reg_addr;
    logic [7:0] ri_val;
    logic [7:0] left;
    logic [7:0] right;
    logic [7:0] dec_val;
    bit_byte_addr = op1[7] ? {op1[7:3], 3'b000} : BIT_AREA_BASE + {4'h0, op1[6:3]};
    bit_byte = rd_direct(bit_byte_addr);
    bit_val = bit_byte[op1[2:0]];
    rel = (kind == K_JB || kind == K_JNB || kind == K_JBCLR || kind == K_CMP_AD || kind == K_CMP_AI ||
           kind == K_CMP_RI || kind == K_CMP_II || kind == K_DECJ_D) ? op2 : op1;
    rel_target = fallthrough + {{8{rel[7]}}, rel};
    reg_addr = {3'b000, psw[BANK_LSB +: 2], cur_op[2:0]};
    ri_val = iram[{3'b000, psw[BANK_LSB +: 2], 2'b00, cur_op[0]}];
    left = (kind == K_CMP_RI) ? iram[reg_addr] : (kind == K_CMP_II) ? iram[ri_val] : arith_primary_reg;
    right = (kind == K_CMP_AD) ? rd_direct(op1) : op1;
    dec_val = ((kind == K_DECJ_R) ? iram[reg_addr] : rd_direct(op1)) - 8'h01;
    taken = 1'b0;
    target = rel_target;
    dwr_en = 1'b0;
    dwr_addr = bit_byte_addr;
    dwr_data = bit_byte;
    carry_en = 1'b0;
    carry_val = psw[CARRY_POS];
    push = 1'b0;
    pop = 1'b0;
    case (kind)
      K_ANLC: begin
        carry_en = 1'b1;
        carry_val = psw[CARRY_POS] & (bit_val ^ (cur_op == OP_ANL_CN));
      end
      K_ORLC: begin
        carry_en = 1'b1;
        carry_val = psw[CARRY_POS] | (bit_val ^ (cur_op == OP_ORL_CN));
      end
      K_MOVCB: begin
        carry_en = 1'b1;
        carry_val = bit_val;
      end
      K_MOVBC: begin
        dwr_en = 1'b1;
        dwr_data[op1[2:0]] = psw[CARRY_POS];
      end
      K_JC: taken = psw[CARRY_POS];
      K_JNC: taken = ~psw[CARRY_POS];
      K_JB: taken = bit_val;
      K_JNB: taken = ~bit_val;
      K_JBCLR: begin
        taken = bit_val;
        dwr_en = bit_val;
        dwr_data[op1[2:0]] = 1'b0;
      end
      K_CALLA, K_JMPAB: begin
        taken = 1'b1;
        target = {fallthrough[15:11], cur_op[7:5], op1};
        push = (kind == K_CALLA);
      end
      K_CALLL, K_JMPL: begin
        taken = 1'b1;
        target = {op1, op2};
        push = (kind == K_CALLL);
      end
      K_RET: begin
        taken = 1'b1;
        target = {iram[stack_pointer], iram[stack_pointer - 8'h01]};
        pop = 1'b1;
      end
      K_JMPS: taken = 1'b1;
      K_JMPA: begin
        taken = 1'b1;
        target = {data_pointer_high, data_pointer_low} + {8'h00, arith_primary_reg};
      end
      K_JZ: taken = (arith_primary_reg == 8'h00);
      K_JNZ: taken = (arith_primary_reg != 8'h00);
      K_CMP_AD, K_CMP_AI, K_CMP_RI, K_CMP_II: begin
        taken = (left != right);
        carry_en = 1'b1;
        carry_val = (left < right);
      end
      K_DECJ_R, K_DECJ_D: begin
        taken = (dec_val != 8'h00);
        dwr_en = 1'b1;
        dwr_addr = (kind == K_DECJ_R) ? reg_addr : op1;
        dwr_data = dec_val;
      end
      default: taken = 1'b0;
    endcase
  end

  // Program counter, byte capture and cycle sequencing
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pc <= PC_RESET;
      op_pc <= PC_RESET;
      jump_target <= PC_RESET;
      opcode <= BYTE_RESET;
      b1 <= BYTE_RESET;
      b2 <= BYTE_RESET;
      cnt <= 3'h0;
      phase <= PH_FETCH;
    end else if (go && phase == PH_TAKEN) begin
      pc <= jump_target;
      phase <= PH_FETCH;
    end else if (active) begin
      if (phase == PH_FETCH) begin
        opcode <= code_data;
        op_pc <= pc;
      end
      if (cnt == 3'h1) begin
        b1 <= code_data;
      end
      if (cnt == 3'h2) begin
        b2 <= code_data;
      end
      if (exec) begin
        cnt <= 3'h0;
        if (taken && dec.extra) begin
          phase <= PH_TAKEN;
          jump_target <= target;
          pc <= fallthrough;
        end else begin
          phase <= PH_FETCH;
          pc <= taken ? target : fallthrough;
        end
      end else begin
        cnt <= cnt + 3'h1;
        phase <= PH_OPER;
        if (cnt < {1'b0, dec.len}) begin
          pc <= pc + 16'h0001;
        end
      end
    end
  end

  // Data RAM: bus writes, direct writes and stack pushes
  always_ff @(posedge clk) begin
    if (bus_wr && !avs_address[7]) begin
      iram[avs_address] <= avs_writedata[7:0];
    end
    if (exec && dwr_en && !dwr_addr[7]) begin
      iram[dwr_addr] <= dwr_data;
    end
    if (exec && push) begin
      iram[stack_pointer + 8'h01] <= fallthrough[7:0];
      iram[stack_pointer + 8'h02] <= fallthrough[15:8];
    end
  end

  // Stack pointer: pre-increment on push, decrement on return
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      stack_pointer <= STACK_RESET;
    end else if (bus_wr && avs_address == SFR_STACK) begin
      stack_pointer <= avs_writedata[7:0];
    end else if (exec && push) begin
      stack_pointer <= stack_pointer + 8'h02;
    end else if (exec && pop) begin
      stack_pointer <= stack_pointer - 8'h02;
    end else if (exec && dwr_en && dwr_addr == SFR_STACK) begin
      stack_pointer <= dwr_data;
    end
  end

  // Data pointer bytes
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      data_pointer_low <= BYTE_RESET;
      data_pointer_high <= BYTE_RESET;
    end else begin
      if (bus_wr && avs_address == SFR_PTR_LOW) begin
        data_pointer_low <= avs_writedata[7:0];
      end else if (exec && dwr_en && dwr_addr == SFR_PTR_LOW) begin
        data_pointer_low <= dwr_data;
      end
      if (bus_wr && avs_address == SFR_PTR_HIGH) begin
        data_pointer_high <= avs_writedata[7:0];
      end else if (exec && dwr_en && dwr_addr == SFR_PTR_HIGH) begin
        data_pointer_high <= dwr_data;
      end
    end
  end

  // Primary and secondary accumulators, bit-addressable through the direct path
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      arith_primary_reg <= BYTE_RESET;
      arith_secondary_reg <= BYTE_RESET;
    end else begin
      if (bus_wr && avs_address == SFR_ARITH_PRI) begin
        arith_primary_reg <= avs_writedata[7:0];
      end else if (exec && dwr_en && dwr_addr == SFR_ARITH_PRI) begin
        arith_primary_reg <= dwr_data;
      end
      if (bus_wr && avs_address == SFR_ARITH_SEC) begin
        arith_secondary_reg <= avs_writedata[7:0];
      end else if (exec && dwr_en && dwr_addr == SFR_ARITH_SEC) begin
        arith_secondary_reg <= dwr_data;
      end
    end
  end

  // Status word: carry and bank select; parity is derived on read
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      psw <= BYTE_RESET;
    end else if (bus_wr && avs_address == SFR_PSW) begin
      psw <= avs_writedata[7:0];
    end else if (exec && dwr_en && dwr_addr == SFR_PSW) begin
      psw <= dwr_data;
    end else if (exec && carry_en) begin
      psw[CARRY_POS] <= carry_val;
    end
  end

  // Run control, written by software only
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      run <= 1'b0;
    end else if (bus_wr && avs_address == SFR_CTRL) begin
      run <= avs_writedata[RUN_POS];
    end
  end

  // Cycle accounting of the previous instruction, for the checks below
  logic [2:0] h_cnt;
  logic h_valid;
  logic h_taken;
  kind_t h_kind;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      h_cnt <= 3'h0;
      h_valid <= 1'b0;
      h_taken <= 1'b0;
      h_kind <= K_NOP;
    end else begin
      if (start) begin
        h_cnt <= 3'h1;
        h_valid <= 1'b1;
        h_kind <= kind;
      end else if (active || (go && phase == PH_TAKEN)) begin
        h_cnt <= h_cnt + 3'h1;
      end
      if (exec) begin
        h_taken <= taken && dec.extra;
      end
    end
  end

  a_bit_logic_time: assert property (@(posedge clk) disable iff (!rstn)
    start && h_valid && (h_kind == K_ANLC || h_kind == K_ORLC) |-> h_cnt == CYC_BIT)
    else $error("bit logic instruction took wrong cycle count");
  a_bit_move_time: assert property (@(posedge clk) disable iff (!rstn)
    start && h_valid && (h_kind == K_MOVCB || h_kind == K_MOVBC) |-> h_cnt == CYC_BIT)
    else $error("bit move took wrong cycle count");
  a_carry_jump_time: assert property (@(posedge clk) disable iff (!rstn)
    start && h_valid && (h_kind == K_JC || h_kind == K_JNC) |-> h_cnt == (h_taken ? 3'h3 : 3'h2))
    else $error("carry jump took wrong cycle count");
  a_bit_jump_time: assert property (@(posedge clk) disable iff (!rstn)
    start && h_valid && (h_kind == K_JB || h_kind == K_JNB || h_kind == K_JBCLR) |->
    h_cnt == (h_taken ? 3'h4 : 3'h3))
    else $error("bit jump took wrong cycle count");
  a_abs_branch_time: assert property (@(posedge clk) disable iff (!rstn)
    start && h_valid && (h_kind == K_CALLA || h_kind == K_JMPAB) |-> h_cnt == CYC_ABS)
    else $error("absolute branch took wrong cycle count");
  a_abs_page_kept: assert property (@(posedge clk) disable iff (!rstn)
    exec && (kind == K_CALLA || kind == K_JMPAB) |=> pc[15:11] == $past(ft_page))
    else $error("absolute branch left its page");
  a_long_branch_time: assert property (@(posedge clk) disable iff (!rstn)
    start && h_valid && (h_kind == K_CALLL || h_kind == K_JMPL) |-> h_cnt == CYC_LONG)
    else $error("long branch took wrong cycle count");
  a_return_time: assert property (@(posedge clk) disable iff (!rstn)
    start && h_valid && h_kind == K_RET |-> h_cnt == CYC_RET)
    else $error("return took wrong cycle count");
  a_zero_jump_time: assert property (@(posedge clk) disable iff (!rstn)
    start && h_valid && (h_kind == K_JZ || h_kind == K_JNZ) |-> h_cnt == (h_taken ? 3'h3 : 3'h2))
    else $error("zero jump took wrong cycle count");
  a_compare_jump_time: assert property (@(posedge clk) disable iff (!rstn)
    start && h_valid && (h_kind == K_CMP_AD || h_kind == K_CMP_II) |-> h_cnt == (h_taken ? 3'h5 : 3'h4))
    else $error("compare jump took wrong cycle count");
  a_nop_one_cycle: assert property (@(posedge clk) disable iff (!rstn)
    start && h_valid && h_kind == K_NOP |-> h_cnt == CYC_NOP)
    else $error("no-operation took more than one cycle");
  a_call_push_sp: assert property (@(posedge clk) disable iff (!rstn)
    exec && (kind == K_CALLA || kind == K_CALLL) |=> stack_pointer == $past(stack_pointer) + 8'h02)
    else $error("call did not advance the stack pointer by two");

endmodule : mcu_core_branch_bit_regs

`default_nettype wire

// ### rtl/mcu_core_pkg.sv
// Constants, encodings and types for the branch and bit-instruction core.
// Assumes one 40 MHz clock and an Avalon-MM register slave with word addressing.
`default_nettype none

package mcu_core_pkg;
  // Special register offsets, also the bus word index
  localparam logic [7:0] SFR_STACK = 8'h81;
  localparam logic [7:0] SFR_PTR_LOW = 8'h82;
  localparam logic [7:0] SFR_PTR_HIGH = 8'h83;
  localparam logic [7:0] SFR_PC_LOW = 8'h8C;
  localparam logic [7:0] SFR_PC_HIGH = 8'h8D;
  localparam logic [7:0] SFR_CTRL = 8'h8E;
  localparam logic [7:0] SFR_PSW = 8'hD0;
  localparam logic [7:0] SFR_ARITH_PRI = 8'hE0;
  localparam logic [7:0] SFR_ARITH_SEC = 8'hF0;
  // Reset values and field positions
  localparam logic [7:0] STACK_RESET = 8'h07;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [15:0] PC_RESET = 16'h0000;
  localparam logic [7:0] BIT_AREA_BASE = 8'h20;
  localparam int CARRY_POS = 7;
  localparam int BANK_LSB = 3;
  localparam int RUN_POS = 0;
  // Opcodes
  localparam logic [7:0] OP_ANL_C = 8'h82;
  localparam logic [7:0] OP_ANL_CN = 8'hB0;
  localparam logic [7:0] OP_ORL_C = 8'h72;
  localparam logic [7:0] OP_ORL_CN = 8'hA0;
  localparam logic [7:0] OP_MOV_CB = 8'hA2;
  localparam logic [7:0] OP_MOV_BC = 8'h92;
  localparam logic [7:0] OP_JC = 8'h40;
  localparam logic [7:0] OP_JNC = 8'h50;
  localparam logic [7:0] OP_JB = 8'h20;
  localparam logic [7:0] OP_JNB = 8'h30;
  localparam logic [7:0] OP_JMP_BIT_CLR = 8'h10;
  localparam logic [7:0] OP_CALL_LONG = 8'h12;
  localparam logic [7:0] OP_JMP_LONG = 8'h02;
  localparam logic [7:0] OP_RET = 8'h22;
  localparam logic [7:0] OP_RET_INT = 8'h32;
  localparam logic [7:0] OP_JMP_SHORT = 8'h80;
  localparam logic [7:0] OP_JMPA = 8'h73;
  localparam logic [7:0] OP_JZ = 8'h60;
  localparam logic [7:0] OP_JNZ = 8'h70;
  localparam logic [7:0] OP_CMP_AD = 8'hB5;
  localparam logic [7:0] OP_CMP_AI = 8'hB4;
  localparam logic [7:0] OP_DEC_JMP_D = 8'hD5;
  localparam logic [7:0] OP_NOP = 8'h00;
  localparam logic [7:0] OP_SPARE_NOP = 8'hA5;
  localparam logic [4:0] OP_JMP_ABS_LOW = 5'h01;
  localparam logic [4:0] OP_CALL_ABS_LOW = 5'h11;
  localparam logic [4:0] OP_CMP_RN_HI = 5'h17;
  localparam logic [4:0] OP_DEC_JMP_RN_HI = 5'h1B;
  localparam logic [6:0] OP_CMP_IND_HI = 7'h5B;
  // Byte lengths and base cycle counts
  localparam logic [1:0] LEN_ONE = 2'h1;
  localparam logic [1:0] LEN_TWO = 2'h2;
  localparam logic [1:0] LEN_THREE = 2'h3;
  localparam logic [2:0] CYC_NOP = 3'h1;
  localparam logic [2:0] CYC_BIT = 3'h2;
  localparam logic [2:0] CYC_JC = 3'h2;
  localparam logic [2:0] CYC_JB = 3'h3;
  localparam logic [2:0] CYC_ABS = 3'h3;
  localparam logic [2:0] CYC_LONG = 3'h4;
  localparam logic [2:0] CYC_RET = 3'h5;
  localparam logic [2:0] CYC_SHORT = 3'h3;
  localparam logic [2:0] CYC_JZ = 3'h2;
  localparam logic [2:0] CYC_CMP_MEM = 3'h4;
  localparam logic [2:0] CYC_CMP_IMM = 3'h3;
  localparam logic [2:0] CYC_DEC_R = 3'h2;
  localparam logic [2:0] CYC_DEC_D = 3'h3;

  typedef enum logic [1:0] {PH_FETCH = 2'b00, PH_OPER = 2'b01, PH_TAKEN = 2'b10} phase_t;
  typedef enum logic [4:0] {
    K_NOP = 5'h00, K_ANLC = 5'h01, K_ORLC = 5'h02, K_MOVCB = 5'h03, K_MOVBC = 5'h04,
    K_JC = 5'h05, K_JNC = 5'h06, K_JB = 5'h07, K_JNB = 5'h08, K_JBCLR = 5'h09,
    K_CALLA = 5'h0A, K_JMPAB = 5'h0B, K_CALLL = 5'h0C, K_JMPL = 5'h0D, K_RET = 5'h0E,
    K_JMPS = 5'h0F, K_JMPA = 5'h10, K_JZ = 5'h11, K_JNZ = 5'h12, K_CMP_AD = 5'h13,
    K_CMP_AI = 5'h14, K_CMP_RI = 5'h15, K_CMP_II = 5'h16, K_DECJ_R = 5'h17, K_DECJ_D = 5'h18
  } kind_t;
  typedef struct packed {
    logic [1:0] len;
    logic [2:0] base;
    logic extra;
  } dec_t;
endpackage : mcu_core_pkg

`default_nettype wire

// ### bench/mcu_core_branch_bit_regs_tb_top.sv
// Self-checking bench for the branch and bit-instruction core.
// Assumes the core package; code memory is modelled here as a combinational array.
`default_nettype none
module mcu_core_branch_bit_regs_tb_top
  import mcu_core_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [7:0] addr, init, wval, back;} row_t;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic avs_waitrequest;
  logic [3:0] avs_byteenable = 4'hF;
  logic [7:0] avs_address = 8'h00;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic [31:0] seen;
  logic [15:0] code_addr;
  int num_errors = 0;
  int comparisons = 0;
  int t;
  int n;
  // Program: short jump, long jump, no-ops, carry jump untaken, long call, return, absolute self loop
  logic [7:0] mem [0:255] = '{0: 8'h80, 1: 8'h02, 4: 8'h02, 6: 8'h10, 17: 8'hA5, 18: 8'h40, 19: 8'h05,
    20: 8'h12, 22: 8'h30, 23: 8'h01, 24: 8'h17, 48: 8'h22, default: 8'h00};
  // Register rows: offset, reset value, written value, value read back
  row_t rows [7] = '{'{8'h81, 8'h07, 8'h3C, 8'h3C}, '{8'h82, 8'h00, 8'hA5, 8'hA5}, '{8'h83, 8'h00, 8'hC3, 8'hC3},
    '{8'hE0, 8'h00, 8'h81, 8'h81}, '{8'hF0, 8'h00, 8'h7E, 8'h7E}, '{8'h85, 8'h00, 8'h5A, 8'h00},
    '{8'h8C, 8'h00, 8'hFF, 8'h00}};
  // Instruction start times and their fetch addresses
  int tt [8] = '{3, 7, 8, 9, 11, 15, 20, 23};
  logic [7:0] ta [8] = '{8'h04, 8'h10, 8'h11, 8'h12, 8'h14, 8'h30, 8'h17, 8'h17};

  mcu_core_branch_bit_regs dut (.clk(clk), .rstn(rstn), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .code_addr(code_addr),
    .code_data(mem[code_addr[7:0]]));

  // Clock source
  initial begin
    forever #12.5 clk = ~clk;
  end

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : give_verdict

  task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // One bus access, held until waitrequest is seen low
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    int k;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_read <= !w;
    avs_write <= w;
    for (k = 0; k < 20; k++) begin
      @(posedge clk);
      if (avs_waitrequest === 1'b0) break;
    end
    seen = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (k == 20) begin
      num_errors++;
      give_verdict();
    end
  endtask : bus

  // Main sequence
  initial begin
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    foreach (rows[i]) begin
      bus(1'b0, rows[i].addr, 8'h00);
      check("reset value", seen, {24'h0, rows[i].init});
      bus(1'b1, rows[i].addr, rows[i].wval);
      bus(1'b0, rows[i].addr, 8'h00);
      check("read back", seen, {24'h0, rows[i].back});
    end
    avs_byteenable <= 4'hE;
    bus(1'b1, SFR_ARITH_SEC, 8'h11);
    avs_byteenable <= 4'hF;
    bus(1'b0, SFR_ARITH_SEC, 8'h00);
    check("masked write", seen, 32'h7E);
    $display("register table test done");
    bus(1'b1, SFR_CTRL, 8'h01);
    for (n = 0; n < 50 && code_addr !== 16'h0001; n++) @(negedge clk);
    if (n == 50) begin
      num_errors++;
      give_verdict();
    end
    t = 1;
    foreach (tt[i]) begin
      repeat (tt[i] - t) @(negedge clk);
      t = tt[i];
      check("fetch address", {16'h0, code_addr}, {24'h0, ta[i]});
    end
    $display("branch timing test done");
    @(posedge clk);
    rstn <= 1'b0;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    bus(1'b0, SFR_STACK, 8'h00);
    check("stack pointer after reset", seen, 32'h07);
    check("fetch address after reset", {16'h0, code_addr}, 32'h0);
    $display("second reset test done");
    give_verdict();
  end
endmodule : mcu_core_branch_bit_regs_tb_top
`default_nettype wire
